/* shared/scss_pkg.sv */
// Package: register map, field layout and types of the system clock source select block
package scss_pkg;

   localparam int SCSS_AW = 12;
   localparam int SCSS_DW = 32;

   // Register byte offsets
   localparam logic [11:0] SCSS_OFS_CTRL = 12'h000;
   localparam logic [11:0] SCSS_OFS_PLL_SETUP = 12'h004;
   localparam logic [11:0] SCSS_OFS_DIVIDERS = 12'h008;
   localparam logic [11:0] SCSS_OFS_PLL_RATIO = 12'h00C;
   localparam logic [11:0] SCSS_OFS_STATUS = 12'h010;

   // Field positions
   localparam int SCSS_POS_CLOCK_SOURCE_SELECT = 0;
   localparam int SCSS_POS_BYPASS = 0;
   localparam int SCSS_POS_BAND = 1;
   localparam int SCSS_POS_INSEL = 3;
   localparam int SCSS_POS_K1 = 0;
   localparam int SCSS_POS_K2 = 16;
   localparam int SCSS_POS_PLL_INPUT_DIVIDER = 0;
   localparam int SCSS_POS_NMUL = 8;
   localparam int SCSS_POS_ACT = 0;
   localparam int SCSS_POS_SWITCHING = 2;
   localparam int SCSS_POS_LOCK = 3;

   // Field widths
   localparam int SCSS_K1_W = 10;
   localparam int SCSS_K2_W = 7;
   localparam int SCSS_P_W = 4;
   localparam int SCSS_N_W = 7;
   localparam int SCSS_PER_W = 16;
   localparam int SCSS_ACC_W = 24;

   // Clock source select codes
   localparam logic [1:0] SCSS_SEL_WAKEUP = 2'h0;
   localparam logic [1:0] SCSS_SEL_RSVD = 2'h1;
   localparam logic [1:0] SCSS_SEL_PLL = 2'h2;
   localparam logic [1:0] SCSS_SEL_DIRECT = 2'h3;

   // Band codes; bit 1 set is reserved
   localparam logic [1:0] SCSS_BAND_LOW = 2'h0;
   localparam logic [1:0] SCSS_BAND_HIGH = 2'h1;

   // Reset values
   localparam logic [1:0] SCSS_RST_CLOCK_SOURCE_SELECT = SCSS_SEL_WAKEUP;
   localparam logic SCSS_RST_BYPASS = 1'b1;
   localparam logic [1:0] SCSS_RST_BAND = SCSS_BAND_LOW;
   localparam logic SCSS_RST_INSEL = 1'b0;
   localparam logic [9:0] SCSS_RST_K1 = 10'h000;
   localparam logic [6:0] SCSS_RST_K2 = 7'h00;
   localparam logic [3:0] SCSS_RST_PLL_INPUT_DIVIDER = 4'h0;
   localparam logic [6:0] SCSS_RST_NMUL = 7'h00;

   // Active generation mode
   typedef enum logic [1:0] {
      SCSS_MODE_WAKEUP = 2'h0,
      SCSS_MODE_PRESC = 2'h1,
      SCSS_MODE_PLL = 2'h2,
      SCSS_MODE_DIRECT = 2'h3
   } scss_mode_t;

   typedef struct packed {
      logic [1:0] clock_source_select;
      logic vco_bypass;
      logic [1:0] vco_band_select;
      logic input_source_select;
      logic [9:0] output_prescaler_divider;
      logic [6:0] vco_output_divider;
      logic [3:0] pll_input_divider;
      logic [6:0] pll_multiplier;
   } scss_cfg_t;

   typedef struct packed {
      logic wakeup;
      logic internal;
      logic oscillator;
      logic direct;
   } scss_src_t;

endpackage

/* logic/scss_top.sv */
// System clock source selection and generation with APB control registers
//
// Operation
// - Select code 11 passes the direct clock input unchanged as system clock.
// - Select 10 with bypass 1 divides oscillator clock by output prescaler plus one.
// - Prescaler input is the oscillator input or the internal clock source.
// - Prescaler factor one passes the oscillator clock with its own high/low times.
// - Output prescaler divides by up to 1024.
// - Select 10 with bypass 0 enables PLL; output is input times factor F.
// - F equals N over P times K2, each field plus one.
// - PLL input is the oscillator input pin or the on-chip clock source.
// - PLL period estimate moves gradually; writes of N, P or K2 change the frequency at once.
// - System clock is the VCO output divided by K2 plus one.
// - Band code 00 low band, 01 high band; 1X reserved, refused.
// - Select code 00 takes the wakeup clock source directly.
`timescale 1ns/1ps
`default_nettype none

module scss_top
   import scss_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [SCSS_AW-1:0] PADDR,
   input wire logic [SCSS_DW-1:0] PWDATA,
   output logic [SCSS_DW-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic DIRECT_CLOCK_INPUT,
   input wire logic OSCILLATOR_INPUT_PIN,
   input wire logic INTERNAL_CLK_IN,
   input wire logic WAKEUP_CLK_IN,
   output logic SYS_CLK,
   output logic PLL_ENABLE
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   scss_cfg_t cfg_ff;
   scss_src_t src_ff;
   scss_mode_t tgt_mode;
   scss_mode_t act_ff;
   logic [SCSS_DW-1:0] nxt_prdata;
   logic nxt_pslverr;
   logic [SCSS_DW-1:0] prdata_ff;
   logic pslverr_ff;
   logic wr_acc;
   logic rd_acc;
   logic hit;
   logic gen_src;
   logic gen_prev_ff;
   logic [SCSS_K1_W:0] k1_val;
   logic [SCSS_K1_W-1:0] k1_cnt_ff;
   logic presc_clk;
   logic [SCSS_PER_W-1:0] per_cnt_ff;
   logic [SCSS_PER_W-1:0] per_meas_ff;
   logic [SCSS_PER_W-1:0] per_filt_ff;
   logic [SCSS_ACC_W-1:0] acc_ff;
   logic [SCSS_ACC_W-1:0] acc_sum;
   logic [SCSS_ACC_W-1:0] thresh;
   logic vco_tick;
   logic [SCSS_K2_W-1:0] k2_cnt_ff;
   logic pll_clk_ff;
   logic [3:0] cand;
   logic sys_ff;
   logic in_rise;
   logic act_insel_ff;
   logic [SCSS_K1_W-1:0] act_k1_ff;
   logic cfg_chg;

   typedef enum logic [1:0] {SW_RUN, SW_WAIT_OLD, SW_WAIT_NEW} scss_sw_t;
   scss_sw_t sw_ff;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign wr_acc = PSEL & PENABLE & PWRITE;
   assign rd_acc = PSEL & PENABLE & ~PWRITE;
   assign hit = (PADDR == SCSS_OFS_CTRL) | (PADDR == SCSS_OFS_PLL_SETUP) | (PADDR == SCSS_OFS_DIVIDERS) |
                (PADDR == SCSS_OFS_PLL_RATIO) | (PADDR == SCSS_OFS_STATUS);
   assign PREADY = 1'b1;
   assign PRDATA = prdata_ff;
   assign PSLVERR = pslverr_ff & PSEL & PENABLE;

   always_comb begin
      nxt_prdata = '0;
      nxt_pslverr = ~hit;
      unique case (PADDR)
         SCSS_OFS_CTRL: nxt_prdata[SCSS_POS_CLOCK_SOURCE_SELECT +: 2] = cfg_ff.clock_source_select;
         SCSS_OFS_PLL_SETUP: begin
            nxt_prdata[SCSS_POS_BYPASS] = cfg_ff.vco_bypass;
            nxt_prdata[SCSS_POS_BAND +: 2] = cfg_ff.vco_band_select;
            nxt_prdata[SCSS_POS_INSEL] = cfg_ff.input_source_select;
         end
         SCSS_OFS_DIVIDERS: begin
            nxt_prdata[SCSS_POS_K1 +: SCSS_K1_W] = cfg_ff.output_prescaler_divider;
            nxt_prdata[SCSS_POS_K2 +: SCSS_K2_W] = cfg_ff.vco_output_divider;
         end
         SCSS_OFS_PLL_RATIO: begin
            nxt_prdata[SCSS_POS_PLL_INPUT_DIVIDER +: SCSS_P_W] = cfg_ff.pll_input_divider;
            nxt_prdata[SCSS_POS_NMUL +: SCSS_N_W] = cfg_ff.pll_multiplier;
         end
         SCSS_OFS_STATUS: begin
            nxt_prdata[SCSS_POS_ACT +: 2] = act_ff;
            nxt_prdata[SCSS_POS_SWITCHING] = (sw_ff != SW_RUN);
            nxt_prdata[SCSS_POS_LOCK] = (per_filt_ff == per_meas_ff) && (per_meas_ff != '0);
         end
         default: nxt_prdata = '0;
      endcase
   end

   // Read word and error captured in setup, held through the access phase
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         prdata_ff <= PWRITE ? '0 : nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end else if (!PSEL) begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_ff.clock_source_select <= SCSS_RST_CLOCK_SOURCE_SELECT;
         cfg_ff.vco_bypass <= SCSS_RST_BYPASS;
         cfg_ff.vco_band_select <= SCSS_RST_BAND;
         cfg_ff.input_source_select <= SCSS_RST_INSEL;
         cfg_ff.output_prescaler_divider <= SCSS_RST_K1;
         cfg_ff.vco_output_divider <= SCSS_RST_K2;
         cfg_ff.pll_input_divider <= SCSS_RST_PLL_INPUT_DIVIDER;
         cfg_ff.pll_multiplier <= SCSS_RST_NMUL;
      end else if (wr_acc) begin
         unique case (PADDR)
            SCSS_OFS_CTRL: cfg_ff.clock_source_select <= PWDATA[SCSS_POS_CLOCK_SOURCE_SELECT +: 2];
            SCSS_OFS_PLL_SETUP: begin
               cfg_ff.vco_bypass <= PWDATA[SCSS_POS_BYPASS];
               cfg_ff.input_source_select <= PWDATA[SCSS_POS_INSEL];
               if (!PWDATA[SCSS_POS_BAND + 1]) begin
                  cfg_ff.vco_band_select <= PWDATA[SCSS_POS_BAND +: 2];
               end
            end
            SCSS_OFS_DIVIDERS: begin
               cfg_ff.output_prescaler_divider <= PWDATA[SCSS_POS_K1 +: SCSS_K1_W];
               cfg_ff.vco_output_divider <= PWDATA[SCSS_POS_K2 +: SCSS_K2_W];
            end
            SCSS_OFS_PLL_RATIO: begin
               cfg_ff.pll_input_divider <= PWDATA[SCSS_POS_PLL_INPUT_DIVIDER +: SCSS_P_W];
               cfg_ff.pll_multiplier <= PWDATA[SCSS_POS_NMUL +: SCSS_N_W];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source sampling and target mode
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         src_ff <= '0;
      end else begin
         src_ff.wakeup <= WAKEUP_CLK_IN;
         src_ff.internal <= INTERNAL_CLK_IN;
         src_ff.oscillator <= OSCILLATOR_INPUT_PIN;
         src_ff.direct <= DIRECT_CLOCK_INPUT;
      end
   end

   always_comb begin
      unique case (cfg_ff.clock_source_select)
         SCSS_SEL_DIRECT: tgt_mode = SCSS_MODE_DIRECT;
         SCSS_SEL_PLL: tgt_mode = cfg_ff.vco_bypass ? SCSS_MODE_PRESC : SCSS_MODE_PLL;
         default: tgt_mode = SCSS_MODE_WAKEUP;
      endcase
   end

   assign PLL_ENABLE = (cfg_ff.clock_source_select == SCSS_SEL_PLL) & ~cfg_ff.vco_bypass;

   // Common input for prescaler and PLL
   assign gen_src = act_insel_ff ? src_ff.internal : src_ff.oscillator;
   assign in_rise = gen_src & ~gen_prev_ff;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         gen_prev_ff <= 1'b0;
      end else begin
         gen_prev_ff <= gen_src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output prescaler
   assign k1_val = {1'b0, act_k1_ff} + 11'h001;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         k1_cnt_ff <= '0;
      end else if (in_rise) begin
         if ({1'b0, k1_cnt_ff} >= k1_val - 11'h001) begin
            k1_cnt_ff <= '0;
         end else begin
            k1_cnt_ff <= k1_cnt_ff + 10'h001;
         end
      end
   end

   // Factor one passes the input level straight through
   assign presc_clk = (act_k1_ff == '0) ? gen_src :
                      ({1'b0, k1_cnt_ff} < (k1_val >> 1));

   ////////////////////////////////////////////////////////////////////////////
   // PLL: input period tracking
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         per_cnt_ff <= '0;
         per_meas_ff <= '0;
      end else if (in_rise) begin
         per_cnt_ff <= 16'h0001;
         per_meas_ff <= per_cnt_ff;
      end else if (per_cnt_ff != 16'hFFFF) begin
         per_cnt_ff <= per_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         per_filt_ff <= '0;
      end else if (in_rise && PLL_ENABLE) begin
         if (per_filt_ff < per_meas_ff) begin
            per_filt_ff <= per_filt_ff + 16'h0001;
         end else if (per_filt_ff > per_meas_ff) begin
            per_filt_ff <= per_filt_ff - 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL: numeric VCO, two half-period ticks per VCO cycle
   assign thresh = SCSS_ACC_W'({4'h0, per_filt_ff} * ({16'h0, cfg_ff.pll_input_divider} + 20'h00001));
   assign acc_sum = acc_ff + SCSS_ACC_W'({cfg_ff.pll_multiplier, 1'b0}) + 24'h000002;
   assign vco_tick = PLL_ENABLE && (thresh != '0) && (acc_sum >= thresh);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_ff <= '0;
      end else if (!PLL_ENABLE) begin
         acc_ff <= '0;
      end else if (vco_tick) begin
         acc_ff <= acc_sum - thresh;
      end else if (thresh != '0) begin
         acc_ff <= acc_sum;
      end
   end

   // Divide VCO by K2 plus one: toggle after K2 plus one half ticks
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         k2_cnt_ff <= '0;
         pll_clk_ff <= 1'b0;
      end else if (!PLL_ENABLE) begin
         k2_cnt_ff <= '0;
         pll_clk_ff <= 1'b0;
      end else if (vco_tick) begin
         if (k2_cnt_ff >= cfg_ff.vco_output_divider) begin
            k2_cnt_ff <= '0;
            pll_clk_ff <= ~pll_clk_ff;
         end else begin
            k2_cnt_ff <= k2_cnt_ff + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Glitch-free source switch
   assign cand[SCSS_MODE_WAKEUP] = src_ff.wakeup;
   assign cand[SCSS_MODE_PRESC] = presc_clk;
   assign cand[SCSS_MODE_PLL] = pll_clk_ff;
   assign cand[SCSS_MODE_DIRECT] = src_ff.direct;

   ////////////////////////////////////////////////////////////////////////////
   // Applied generator settings
   // Pending input select or prescaler divider change parks the output like a source change
   assign cfg_chg = (cfg_ff.input_source_select != act_insel_ff) |
                    (cfg_ff.output_prescaler_divider != act_k1_ff);

   // Generator input and divider take effect only while the output is low
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         act_insel_ff <= SCSS_RST_INSEL;
         act_k1_ff <= SCSS_RST_K1;
      end else if ((sw_ff == SW_WAIT_OLD) && !cand[act_ff]) begin
         act_insel_ff <= cfg_ff.input_source_select;
         act_k1_ff <= cfg_ff.output_prescaler_divider;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switch sequencer

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_ff <= SW_RUN;
         act_ff <= SCSS_MODE_WAKEUP;
         sys_ff <= 1'b0;
      end else begin
         unique case (sw_ff)
            SW_RUN: begin
               sys_ff <= cand[act_ff];
               if ((tgt_mode != act_ff) || cfg_chg) begin
                  sw_ff <= SW_WAIT_OLD;
               end
            end
            SW_WAIT_OLD: begin
               sys_ff <= cand[act_ff];
               if (!cand[act_ff]) begin
                  sw_ff <= SW_WAIT_NEW;
               end
            end
            SW_WAIT_NEW: begin
               sys_ff <= 1'b0;
               if (!cand[tgt_mode]) begin
                  act_ff <= tgt_mode;
                  sw_ff <= SW_RUN;
               end
            end
         endcase
      end
   end

   assign SYS_CLK = sys_ff;

endmodule // scss_top

`default_nettype wire

/* test/scss_src_model.sv */
// Free-running clock sources on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module scss_src_model
   import scss_pkg::*;
#(
   parameter int DIR_HP = 3,
   parameter int OSC_HP = 4,
   parameter int INT_HP = 5,
   parameter int WU_HP = 7
)(
   input wire logic clk,
   input wire logic rst_n,
   output var scss_src_t src
);
   localparam int HP [4] = '{DIR_HP, OSC_HP, INT_HP, WU_HP};
   int cnt_ff [4];
   // Oscillators keep running, each at its own half period
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src <= '0;
         cnt_ff <= '{default: 0};
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (cnt_ff[i] == HP[i] - 1) begin
               cnt_ff[i] <= 0;
               src[i] <= ~src[i];
            end else begin
               cnt_ff[i] <= cnt_ff[i] + 1;
            end
         end
      end
   end
endmodule // scss_src_model
`default_nettype wire

/* test/scss_top_properties.sv */
// Assertion checker bound to the clock source select block
`timescale 1ns/1ps
`default_nettype none
module scss_chk
   import scss_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [SCSS_AW-1:0] PADDR,
   input wire logic [SCSS_DW-1:0] PWDATA,
   input wire logic [SCSS_DW-1:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic DIRECT_CLOCK_INPUT,
   input wire logic OSCILLATOR_INPUT_PIN,
   input wire logic INTERNAL_CLK_IN,
   input wire logic WAKEUP_CLK_IN,
   input wire logic SYS_CLK,
   input wire logic PLL_ENABLE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   logic wr, settled;
   logic [1:0] sel_ff, band_ff;
   logic byp_ff, ins_ff;
   logic [9:0] k1_ff;
   logic [5:0] cnt_ff;
   assign wr = PSEL && PENABLE && PWRITE && PREADY;
   assign settled = cnt_ff == 6'h3F;
   // Shadow of the control fields
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_ff <= SCSS_RST_CLOCK_SOURCE_SELECT;
         {band_ff, byp_ff, ins_ff} <= {SCSS_RST_BAND, SCSS_RST_BYPASS, SCSS_RST_INSEL};
         k1_ff <= SCSS_RST_K1;
      end else if (wr) begin
         if (PADDR == SCSS_OFS_CTRL) sel_ff <= PWDATA[1:0];
         if (PADDR == SCSS_OFS_PLL_SETUP) {ins_ff, byp_ff} <= {PWDATA[3], PWDATA[0]};
         if (PADDR == SCSS_OFS_PLL_SETUP && !PWDATA[2]) band_ff <= PWDATA[2:1];
         if (PADDR == SCSS_OFS_DIVIDERS) k1_ff <= PWDATA[9:0];
      end
   end
   // Cycles since the last write, saturating
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) cnt_ff <= 6'h00;
      else if (wr) cnt_ff <= 6'h00;
      else if (!settled) cnt_ff <= cnt_ff + 6'h01;
   end
   ////////////////////////////////////////////////////////////
   sequence s_access;
      PSEL && PENABLE;
   endsequence
   sequence s_rd_setup;
      s_access ##0 (!PWRITE && PADDR == SCSS_OFS_PLL_SETUP);
   endsequence
   AST_READY: assert property (s_access |-> PREADY) else $error("access not ready");
   AST_UNMAPPED: assert property (s_access ##0 PADDR > SCSS_OFS_STATUS |-> PSLVERR)
      else $error("unmapped access without error");
   AST_BAND: assert property (s_rd_setup |-> PRDATA[2:0] == {band_ff, byp_ff})
      else $error("setup readback wrong");
   AST_PLL_ENABLE: assert property (PLL_ENABLE == (sel_ff == SCSS_SEL_PLL && !byp_ff))
      else $error("pll enable wrong");
   AST_DIRECT: assert property (settled && sel_ff == SCSS_SEL_DIRECT
      |-> SYS_CLK == $past(DIRECT_CLOCK_INPUT, 2))
      else $error("direct clock not followed");
   AST_WAKEUP: assert property (settled && sel_ff[1] == 1'b0 |-> SYS_CLK == $past(WAKEUP_CLK_IN, 2))
      else $error("wakeup clock not followed");
   AST_DIV_ONE: assert property (settled && sel_ff == SCSS_SEL_PLL && byp_ff && k1_ff == 10'h000
      |-> SYS_CLK == (ins_ff ? $past(INTERNAL_CLK_IN, 2) : $past(OSCILLATOR_INPUT_PIN, 2)))
      else $error("prescaler by one not following source");
   AST_HIGH_MIN: assert property ($rose(SYS_CLK) |-> SYS_CLK [*2])
      else $error("runt high pulse");
   AST_LOW_MIN: assert property ($fell(SYS_CLK) |-> !SYS_CLK [*2])
      else $error("runt low pulse");
endmodule // scss_chk
bind scss_top scss_chk chk_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .DIRECT_CLOCK_INPUT(DIRECT_CLOCK_INPUT), .OSCILLATOR_INPUT_PIN(OSCILLATOR_INPUT_PIN),
   .INTERNAL_CLK_IN(INTERNAL_CLK_IN), .WAKEUP_CLK_IN(WAKEUP_CLK_IN), .SYS_CLK(SYS_CLK), .PLL_ENABLE(PLL_ENABLE));
`default_nettype wire

/* test/tb_system_clock_source_select.sv */
// Self-checking testbench of the clock source select block
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_source_select
   import scss_pkg::*;
;
   localparam int DP = 6;
   localparam int OP = 8;
   localparam int IP = 10;
   localparam int WP = 14;
   logic clk, rst_n, psel, pen, pwr, pready, pslverr, er, sys_clk, pll_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   scss_src_t src;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int p;
   scss_top dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DIRECT_CLOCK_INPUT(src.direct),
      .OSCILLATOR_INPUT_PIN(src.oscillator), .INTERNAL_CLK_IN(src.internal), .WAKEUP_CLK_IN(src.wakeup),
      .SYS_CLK(sys_clk), .PLL_ENABLE(pll_en));
   scss_src_model #(.DIR_HP(DP / 2), .OSC_HP(OP / 2), .INT_HP(IP / 2), .WU_HP(WP / 2)) src_u (.clk(clk),
      .rst_n(rst_n), .src(src));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         results;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task chk_near(input int got, input int exp);
      num_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         n_errors++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // Write, skip two periods, then time n periods
   task run(input logic [11:0] a, input logic [31:0] d, input int n);
      time t0;
      apb(1'b1, a, d);
      repeat (2) @(posedge sys_clk);
      t0 = $time;
      repeat (n) @(posedge sys_clk);
      p = int'(($time - t0) / 50);
   endtask
   ////////////////////////////////////////////////////////////
   task t_reset;
      apb(1'b0, SCSS_OFS_CTRL, 32'h0);
      chk(rd, {30'h0, SCSS_RST_CLOCK_SOURCE_SELECT});
      apb(1'b0, SCSS_OFS_PLL_SETUP, 32'h0);
      chk(rd, {28'h0, SCSS_RST_INSEL, SCSS_RST_BAND, SCSS_RST_BYPASS});
      apb(1'b0, SCSS_OFS_PLL_RATIO, 32'h0);
      chk(rd, 32'h0);
      chk(pll_en, 1'b0);
      $display("reset test done");
   endtask
   task t_sel;
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_DIRECT}, 16);
      chk(p, 16 * DP);
      chk(pll_en, 1'b0);
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_RSVD}, 4);
      chk(p, 4 * WP);
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_WAKEUP}, 4);
      chk(p, 4 * WP);
      apb(1'b0, 12'h014, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("select test done");
   endtask
   task t_presc;
      apb(1'b1, SCSS_OFS_DIVIDERS, 32'h0);
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_PLL}, 8);
      chk(p, 8 * OP);
      run(SCSS_OFS_PLL_SETUP, 32'h9, 8);
      chk(p, 8 * IP);
      apb(1'b1, SCSS_OFS_PLL_SETUP, 32'h1);
      run(SCSS_OFS_DIVIDERS, 32'h2, 4);
      chk(p, 4 * 3 * OP);
      run(SCSS_OFS_DIVIDERS, 32'h3FF, 1);
      chk(p, 1024 * OP);
      $display("prescaler test done");
   endtask
   task t_pll;
      apb(1'b1, SCSS_OFS_PLL_RATIO, 32'h0301);
      apb(1'b1, SCSS_OFS_DIVIDERS, 32'h0001_0000);
      run(SCSS_OFS_PLL_SETUP, 32'h0, 32);
      chk(pll_en, 1'b1);
      apb(1'b0, SCSS_OFS_STATUS, 32'h0);
      chk(rd[3:0], 4'hA);
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_PLL}, 16);
      chk_near(p, 16 * OP * 2 * 2 / 4);
      run(SCSS_OFS_DIVIDERS, 32'h0003_0000, 16);
      run(SCSS_OFS_CTRL, {30'h0, SCSS_SEL_PLL}, 16);
      chk_near(p, 16 * OP * 2 * 4 / 4);
      $display("pll test done");
   endtask
   task t_band;
      apb(1'b1, SCSS_OFS_PLL_SETUP, 32'h3);
      apb(1'b0, SCSS_OFS_PLL_SETUP, 32'h0);
      chk(rd[2:0], 3'h3);
      apb(1'b1, SCSS_OFS_PLL_SETUP, 32'h5);
      apb(1'b0, SCSS_OFS_PLL_SETUP, 32'h0);
      chk(rd[2:0], 3'h3);
      apb(1'b1, SCSS_OFS_PLL_SETUP, 32'h1);
      apb(1'b0, SCSS_OFS_PLL_SETUP, 32'h0);
      chk(rd[2:0], 3'h1);
      $display("band test done");
   endtask
   initial begin
      rst_n = 1'b0;
      {psel, pen, pwr} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_sel;
      t_presc;
      t_pll;
      t_band;
      results;
   end
endmodule // tb_system_clock_source_select
`default_nettype wire
